// ==== pkg/tcm_map.svh ====
`ifndef TCM_MAP_SVH
`define TCM_MAP_SVH
// How it works
// R1 - Four output modes compare measurement with both setpoints: band, zone, upper, lower.
// R2 - First pulse input maximum rate is selectable, 30 Hz or 10 kHz.
// R3 - Low-speed setting debounces the pulse input to reject contact chatter.
// R4 - One decimal place setting covers measurement and both setpoints.
// R5 - Displayed value is pulses per second times the prescale factor.
// R6 - Prescale factor of one shows the raw frequency in hertz.
// R7 - Averaging: none, or mean of 2, 4 or 8 measurements.
// R8 - New measurement every 200 ms times the averaging count.
// R9 - No pulse within the auto-zero time forces the measurement to zero.
// R10 - Auto-zero time runs 0.1 s to 99.9 s in 0.1 s steps.
// R11 - Auto-zero timer restarts on each rising pulse edge, expires after a quiet interval.
// R12 - After power-up, outputs stay off for the startup time; measurement runs meanwhile.
// R13 - Startup timer starts at reset release; zero means no inhibit.
// R14 - One sinking or sourcing polarity choice applies to the pulse input only; keys and switches ignore it.
// R15 - Colour choices: red, green, red-to-green on output, green-to-red on output.
// R16 - Red-to-green: red with both outputs off, green when either is on.
// R17 - Green-to-red: green with both outputs off, red when either is on.
// R18 - In zone mode the output colour follows only the first output.
// R19 - Operator holds the mode key, then holds first up key 1 s to enter.
// R20 - Entry is ignored if first up key was pressed before the mode key.
// R21 - First up key cycles configurations, limited by the model variant.
// R22 - Default configuration is one-stage preset, two-stage on two-stage variants.
// R23 - Switch monitor shows each of the eight switch pins, stepped by second up key.
// R24 - Switch monitor only works while the first switch pin is on.
// R25 - Entering configuration mode clears value, turns outputs off, halts measuring.
// R26 - Configuration choices take effect only on return to run mode.
// R27 - A changed configuration reinitialises both setpoints on return to run mode.
// R28 - Changed function settings reset measurement and outputs on return to run.

// Register byte offsets
`define TCM_A_CTRL      8'h00
`define TCM_A_PRESCALE  8'h04
`define TCM_A_AUTOZERO  8'h08
`define TCM_A_STARTUP   8'h0C
`define TCM_A_SETPT1    8'h10
`define TCM_A_SETPT2    8'h14
`define TCM_A_FUNCMODE  8'h18
`define TCM_A_STATUS    8'h1C
`define TCM_A_MEAS      8'h20

// Control register fields
`define TCM_F_OMODE     1:0
`define TCM_F_FAST      2
`define TCM_F_DP        4:3
`define TCM_F_AVG       6:5
`define TCM_F_SOURCE    7
`define TCM_F_COLOUR    9:8
`define TCM_F_KEYLOCK   12:10

// Reset values
`define TCM_RST_PRESCALE 17'h003E8
`define TCM_RST_AUTOZERO 10'h3E7
`define TCM_RST_STARTUP  10'h000
`define TCM_AZ_MIN       10'h001
`define TCM_AZ_MAX       10'h3E7
`define TCM_PRESCALE_ONE 32'd1000

// Timing
`define TCM_CLK_HZ       20000000
`define TCM_SAMPLE_MS    200
`define TCM_TENTH_MS     100
`define TCM_HOLD_MS      1000
`define TCM_DEB_MS       1
`define TCM_MS_CYC(ms)   ((`TCM_CLK_HZ / 1000) * (ms))
`define TCM_SAMPLES_PER_S (1000 / `TCM_SAMPLE_MS)
`endif

// ==== pkg/tcm_pkg.sv ====
package tcm_pkg;
   typedef enum logic [1:0] {
      TCM_OM_BAND, TCM_OM_ZONE, TCM_OM_UPPER, TCM_OM_LOWER
   } tcm_omode_e;
   typedef enum logic [1:0] {
      TCM_COL_RED, TCM_COL_GREEN, TCM_COL_R2G, TCM_COL_G2R
   } tcm_colour_e;
   typedef enum logic [2:0] {
      TCM_CFG_PRESET1, TCM_CFG_PRESET2, TCM_CFG_TOTAL, TCM_CFG_BATCH,
      TCM_CFG_DUAL, TCM_CFG_TACHO
   } tcm_cfg_e;
   typedef enum {
      TCM_K_RUN, TCM_K_ARMED, TCM_K_HOLD, TCM_K_CFG, TCM_K_BLOCK
   } tcm_key_e;
   typedef struct packed {
      tcm_omode_e  omode;
      logic        fast;
      logic [1:0]  dp;
      logic [1:0]  averaging_level_setting;
      logic        sourcing;
      tcm_colour_e colour;
      logic [2:0]  keylock;
      logic [16:0] prescale;
      logic [9:0]  autoz;
      logic [9:0]  startup;
   } tcm_set_s;
   typedef struct packed {
      logic [7:0]  adr;
      logic [31:0] dat;
      logic [3:0]  sel;
      logic        we;
      logic        cyc;
      logic        stb;
   } tcm_wb_req_s;
endpackage

// ==== rtl/tcm_top.sv ====
`timescale 1ns/1ps
`include "tcm_map.svh"
module tcm_top #(
   parameter int unsigned SAMPLE_CYC = `TCM_MS_CYC(`TCM_SAMPLE_MS),
   parameter int unsigned TENTH_CYC  = `TCM_MS_CYC(`TCM_TENTH_MS),
   parameter int unsigned HOLD_CYC   = `TCM_MS_CYC(`TCM_HOLD_MS),
   parameter int unsigned DEB_CYC    = `TCM_MS_CYC(`TCM_DEB_MS),
   parameter bit          TWO_STAGE  = 1'b1,
   parameter int unsigned MAX_CFG    = 5
)(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Wishbone slave
   input  wire tcm_pkg::tcm_wb_req_s wb_req_i,
   output logic [31:0]            wb_dat_o,
   output logic                   wb_ack_o,
   // Pins
   input  wire logic              first_pulse_input_i,
   input  wire logic              mode_key_i,
   input  wire logic              up1_key_i,
   input  wire logic              up2_key_i,
   input  wire logic [7:0]        switch_pins_i,
   // Outputs and display
   output logic                   first_setpoint_output_o,
   output logic                   second_setpoint_output_o,
   output logic                   colour_green_o,
   output logic [31:0]            disp_value_o,
   output logic [1:0]             decimal_place_o,
   output logic                   cfg_mode_o
);
   import tcm_pkg::*;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [11:0] sync1_reg;
   logic [11:0] sync2_reg;
   always_ff @(posedge clk_i)
   begin
      sync1_reg <= {switch_pins_i, up2_key_i, up1_key_i, mode_key_i,
                    first_pulse_input_i};
      sync2_reg <= sync1_reg;
   end

   tcm_set_s act_reg;
   tcm_set_s shd_reg;
   logic     pin_pulse;
   logic     k_mode;
   logic     k_up1;
   logic     k_up2;
   logic [7:0] sw_pins;
   // Keys and switches are contact closures; only the pulse input follows
   // the polarity selection, since that is where sourcing sensors connect
   assign pin_pulse = sync2_reg[0] ^ act_reg.sourcing; // R14
   assign k_mode    = sync2_reg[1];
   assign k_up1     = sync2_reg[2];
   assign k_up2     = sync2_reg[3];
   assign sw_pins   = sync2_reg[11:4];

   // ----------------------------------------
   // Pulse filter
   // ----------------------------------------
   logic        filt_reg;
   logic        filt_d_reg;
   logic [31:0] deb_cnt_reg;
   logic        edge_seen;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         filt_reg    <= 1'b0;
         deb_cnt_reg <= 32'h0;
      end
      else if (act_reg.fast || pin_pulse == filt_reg) // R2
      begin
         filt_reg    <= pin_pulse;
         deb_cnt_reg <= 32'h0;
      end
      // Slow setting only accepts a level that stays put; caps the rate
      else if (deb_cnt_reg >= DEB_CYC - 1) // R3
      begin
         filt_reg    <= pin_pulse;
         deb_cnt_reg <= 32'h0;
      end
      else
         deb_cnt_reg <= deb_cnt_reg + 32'h1;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         filt_d_reg <= 1'b0;
      else
         filt_d_reg <= filt_reg;
   end
   assign edge_seen = filt_reg && !filt_d_reg;

   // ----------------------------------------
   // Tenth-second tick, startup and auto-zero
   // ----------------------------------------
   logic [31:0] tick_cnt_reg;
   logic        tick;
   logic [9:0]  start_cnt_reg;
   logic        inhibit_reg;
   logic [9:0]  az_cnt_reg;
   logic        az_zero_reg;
   logic        halt;
   logic        meas_clr;
   assign tick = (tick_cnt_reg >= TENTH_CYC - 1);
   always_ff @(posedge clk_i)
   begin
      if (rst_i || tick)
         tick_cnt_reg <= 32'h0;
      else
         tick_cnt_reg <= tick_cnt_reg + 32'h1;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         start_cnt_reg <= 10'h0;
         inhibit_reg   <= 1'b1;
      end
      else if (start_cnt_reg >= act_reg.startup) // R13
         inhibit_reg <= 1'b0;
      else if (tick)
         start_cnt_reg <= start_cnt_reg + 10'h1; // R12
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i || edge_seen || meas_clr)
      begin
         az_cnt_reg  <= 10'h0; // R11
         az_zero_reg <= rst_i || meas_clr;
      end
      else if (az_cnt_reg >= act_reg.autoz)
         az_zero_reg <= 1'b1; // R9
      else if (tick)
         az_cnt_reg <= az_cnt_reg + 10'h1;
   end

   // ----------------------------------------
   // Sampling, averaging and scaling
   // ----------------------------------------
   logic [31:0] win_cnt_reg;
   logic [31:0] pulse_cnt_reg;
   logic [31:0] sum_reg;
   logic [2:0]  samp_idx_reg;
   logic [31:0] meas_reg;
   logic [2:0]  last_idx;
   logic [31:0] sum_all;
   logic [31:0] freq;
   logic [48:0] scaled;
   logic        win_end;
   assign last_idx = 3'((4'h1 << act_reg.averaging_level_setting) - 4'h1); // R7
   assign win_end  = (win_cnt_reg >= SAMPLE_CYC - 1);
   assign sum_all  = sum_reg + pulse_cnt_reg;
   assign freq     = 32'((sum_all >> act_reg.averaging_level_setting)
                         * `TCM_SAMPLES_PER_S); // R5
   assign scaled   = (49'(freq) * 49'(act_reg.prescale))
                     / 49'(`TCM_PRESCALE_ONE); // R6
   always_ff @(posedge clk_i)
   begin
      if (rst_i || halt || meas_clr)
      begin
         win_cnt_reg   <= 32'h0;
         pulse_cnt_reg <= 32'h0;
         sum_reg       <= 32'h0;
         samp_idx_reg  <= 3'h0;
      end
      else if (win_end)
      begin
         win_cnt_reg   <= 32'h0;
         pulse_cnt_reg <= 32'(edge_seen);
         if (samp_idx_reg >= last_idx) // R8
         begin
            sum_reg      <= 32'h0;
            samp_idx_reg <= 3'h0;
         end
         else
         begin
            sum_reg      <= sum_all;
            samp_idx_reg <= samp_idx_reg + 3'h1;
         end
      end
      else
      begin
         win_cnt_reg <= win_cnt_reg + 32'h1;
         if (edge_seen)
            pulse_cnt_reg <= pulse_cnt_reg + 32'h1;
      end
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i || halt || meas_clr || az_zero_reg)
         meas_reg <= 32'h0; // R9
      else if (win_end && samp_idx_reg >= last_idx)
         meas_reg <= scaled[31:0];
   end

   // ----------------------------------------
   // Configuration selection keys
   // ----------------------------------------
   tcm_key_e    kst_reg;
   logic [31:0] hold_cnt_reg;
   logic        up1_d_reg;
   logic        up2_d_reg;
   logic        mode_d_reg;
   tcm_cfg_e    cfg_act_reg;
   tcm_cfg_e    cfg_pend_reg;
   logic [3:0]  mon_idx_reg;
   logic        cfg_exit;
   logic        up1_rise;
   logic        up2_rise;
   logic        mode_rise;
   assign up1_rise  = k_up1 && !up1_d_reg;
   assign up2_rise  = k_up2 && !up2_d_reg;
   assign mode_rise = k_mode && !mode_d_reg;
   assign cfg_exit  = (kst_reg == TCM_K_CFG) && mode_rise;
   assign halt      = (kst_reg == TCM_K_CFG)
                      || cfg_act_reg != TCM_CFG_TACHO; // R25
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         up1_d_reg  <= 1'b0;
         up2_d_reg  <= 1'b0;
         mode_d_reg <= 1'b0;
      end
      else
      begin
         up1_d_reg  <= k_up1;
         up2_d_reg  <= k_up2;
         mode_d_reg <= k_mode;
      end
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         kst_reg      <= TCM_K_RUN;
         hold_cnt_reg <= 32'h0;
      end
      else
      begin
         unique case (kst_reg)
            TCM_K_RUN:
               if (k_up1)
                  kst_reg <= TCM_K_BLOCK; // R20
               else if (k_mode)
                  kst_reg <= TCM_K_ARMED;
            TCM_K_ARMED:
               if (!k_mode)
                  kst_reg <= TCM_K_RUN;
               else if (k_up1)
               begin
                  kst_reg      <= TCM_K_HOLD;
                  hold_cnt_reg <= 32'h0;
               end
            TCM_K_HOLD:
               if (!k_mode || !k_up1)
                  kst_reg <= (k_mode || k_up1) ? TCM_K_BLOCK : TCM_K_RUN;
               else if (hold_cnt_reg >= HOLD_CYC - 1)
                  kst_reg <= TCM_K_CFG; // R19
               else
                  hold_cnt_reg <= hold_cnt_reg + 32'h1;
            TCM_K_CFG:
               if (mode_rise)
                  kst_reg <= TCM_K_BLOCK;
            TCM_K_BLOCK:
               if (!k_mode && !k_up1)
                  kst_reg <= TCM_K_RUN;
         endcase
      end
   end
   // Entry leaves both keys down; the first up press inside the mode must
   // be a fresh one, so the entry hold does not step the selection
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cfg_act_reg  <= TWO_STAGE ? TCM_CFG_PRESET2 : TCM_CFG_PRESET1; // R22
         cfg_pend_reg <= TWO_STAGE ? TCM_CFG_PRESET2 : TCM_CFG_PRESET1;
         mon_idx_reg  <= 4'h0;
      end
      else if (cfg_exit)
      begin
         cfg_act_reg <= cfg_pend_reg; // R26
         mon_idx_reg <= 4'h0;
      end
      else if (kst_reg == TCM_K_CFG)
      begin
         if (up1_rise)
            cfg_pend_reg <= (32'(cfg_pend_reg) >= MAX_CFG)
                            ? TCM_CFG_PRESET1
                            : tcm_cfg_e'(cfg_pend_reg + 3'h1); // R21
         if (up2_rise && sw_pins[0]) // R24
            mon_idx_reg <= (mon_idx_reg >= 4'h8) ? 4'h0
                           : mon_idx_reg + 4'h1; // R23
         else if (!sw_pins[0])
            mon_idx_reg <= 4'h0;
      end
   end

   // ----------------------------------------
   // Wishbone register file
   // ----------------------------------------
   logic        func_mode_reg;
   logic        func_dirty_reg;
   logic [31:0] sp1_reg;
   logic [31:0] sp2_reg;
   logic        wr;
   logic [31:0] wmask;
   logic [31:0] wdat;
   logic [31:0] ctrl_rd;
   logic [9:0]  az_new;
   logic        func_exit;
   assign wr    = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !wb_ack_o;
   assign wmask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                   {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
   assign func_exit = wr && wb_req_i.adr == `TCM_A_FUNCMODE
                      && wmask[0] && !wb_req_i.dat[0] && func_mode_reg;
   assign meas_clr  = (func_exit && func_dirty_reg) || cfg_exit; // R28
   always_comb
   begin
      ctrl_rd = 32'h0;
      ctrl_rd[`TCM_F_OMODE]   = shd_reg.omode;
      ctrl_rd[`TCM_F_FAST]    = shd_reg.fast;
      ctrl_rd[`TCM_F_DP]      = shd_reg.dp;
      ctrl_rd[`TCM_F_AVG]     = shd_reg.averaging_level_setting;
      ctrl_rd[`TCM_F_SOURCE]  = shd_reg.sourcing;
      ctrl_rd[`TCM_F_COLOUR]  = shd_reg.colour;
      ctrl_rd[`TCM_F_KEYLOCK] = shd_reg.keylock;
   end
   // Byte-lane merge of the write data into the current read view
   function automatic logic [31:0] merge(input logic [31:0] old);
      merge = (old & ~wmask) | (wb_req_i.dat & wmask);
   endfunction
   assign wdat = merge(ctrl_rd);
   assign az_new = 10'(merge(32'(shd_reg.autoz)));
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         shd_reg          <= '0;
         shd_reg.prescale <= `TCM_RST_PRESCALE;
         shd_reg.autoz    <= `TCM_RST_AUTOZERO;
         shd_reg.startup  <= `TCM_RST_STARTUP;
         act_reg          <= '0;
         act_reg.prescale <= `TCM_RST_PRESCALE;
         act_reg.autoz    <= `TCM_RST_AUTOZERO;
         act_reg.startup  <= `TCM_RST_STARTUP;
         func_mode_reg    <= 1'b0;
         func_dirty_reg   <= 1'b0;
      end
      else if (wr && wb_req_i.adr == `TCM_A_FUNCMODE && wmask[0])
      begin
         func_mode_reg  <= wb_req_i.dat[0];
         func_dirty_reg <= wb_req_i.dat[0] && func_dirty_reg;
         if (func_exit)
            act_reg <= shd_reg;
      end
      // Settings only change in function mode; running goes on meanwhile
      else if (wr && func_mode_reg)
      begin
         func_dirty_reg <= 1'b1;
         unique case (wb_req_i.adr)
            `TCM_A_CTRL:
            begin
               shd_reg.omode    <= tcm_omode_e'(wdat[`TCM_F_OMODE]); // R1
               shd_reg.fast     <= wdat[`TCM_F_FAST];
               shd_reg.dp       <= wdat[`TCM_F_DP];
               shd_reg.averaging_level_setting      <= wdat[`TCM_F_AVG];
               shd_reg.sourcing <= wdat[`TCM_F_SOURCE];
               shd_reg.colour   <= tcm_colour_e'(wdat[`TCM_F_COLOUR]); // R15
               shd_reg.keylock  <= wdat[`TCM_F_KEYLOCK];
            end
            `TCM_A_PRESCALE:
               shd_reg.prescale <= 17'(merge(32'(shd_reg.prescale)));
            `TCM_A_AUTOZERO:
               shd_reg.autoz <= (az_new < `TCM_AZ_MIN) ? `TCM_AZ_MIN
                                : (az_new > `TCM_AZ_MAX) ? `TCM_AZ_MAX
                                : az_new; // R10
            `TCM_A_STARTUP:
               shd_reg.startup <= 10'(merge(32'(shd_reg.startup)));
            default:
               func_dirty_reg <= func_dirty_reg;
         endcase
      end
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i || (cfg_exit && cfg_pend_reg != cfg_act_reg)) // R27
      begin
         sp1_reg <= 32'h0;
         sp2_reg <= 32'h0;
      end
      else if (wr && wb_req_i.adr == `TCM_A_SETPT1)
         sp1_reg <= merge(sp1_reg);
      else if (wr && wb_req_i.adr == `TCM_A_SETPT2)
         sp2_reg <= merge(sp2_reg);
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else
      begin
         wb_ack_o <= wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
         unique case (wb_req_i.adr)
            `TCM_A_CTRL:     wb_dat_o <= ctrl_rd;
            `TCM_A_PRESCALE: wb_dat_o <= 32'(shd_reg.prescale);
            `TCM_A_AUTOZERO: wb_dat_o <= 32'(shd_reg.autoz);
            `TCM_A_STARTUP:  wb_dat_o <= 32'(shd_reg.startup);
            `TCM_A_SETPT1:   wb_dat_o <= sp1_reg;
            `TCM_A_SETPT2:   wb_dat_o <= sp2_reg;
            `TCM_A_FUNCMODE: wb_dat_o <= {30'h0, func_dirty_reg,
                                          func_mode_reg};
            `TCM_A_STATUS:   wb_dat_o <= {15'h0, 4'(mon_idx_reg),
                                          1'(inhibit_reg), 3'(cfg_act_reg),
                                          3'(cfg_pend_reg),
                                          1'(kst_reg == TCM_K_CFG),
                                          1'(az_zero_reg), 1'(filt_reg),
                                          1'(colour_green_o),
                                          1'(second_setpoint_output_o),
                                          1'(first_setpoint_output_o)};
            `TCM_A_MEAS:     wb_dat_o <= meas_reg;
            default:         wb_dat_o <= 32'h0;
         endcase
      end
   end

   // ----------------------------------------
   // Comparison, colour and display
   // ----------------------------------------
   logic hi1;
   logic hi2;
   logic lo1;
   logic lo2;
   logic o1;
   logic o2;
   logic on_any;
   assign hi1 = meas_reg >= sp1_reg;
   assign hi2 = meas_reg >= sp2_reg;
   assign lo1 = meas_reg <= sp1_reg;
   assign lo2 = meas_reg <= sp2_reg;
   always_comb
   begin
      unique case (act_reg.omode) // R1
         TCM_OM_BAND:  begin o1 = hi1;        o2 = lo2; end
         TCM_OM_ZONE:  begin o1 = hi2 && lo1; o2 = 1'b0; end
         TCM_OM_UPPER: begin o1 = hi1;        o2 = hi2; end
         TCM_OM_LOWER: begin o1 = lo1;        o2 = lo2; end
      endcase
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i || inhibit_reg || halt || meas_clr) // R12
      begin
         first_setpoint_output_o  <= 1'b0;
         second_setpoint_output_o <= 1'b0;
      end
      else
      begin
         first_setpoint_output_o  <= o1;
         second_setpoint_output_o <= o2;
      end
   end
   assign on_any = (act_reg.omode == TCM_OM_ZONE)
                   ? first_setpoint_output_o // R18
                   : first_setpoint_output_o || second_setpoint_output_o;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         colour_green_o <= 1'b0;
      else
         unique case (act_reg.colour)
            TCM_COL_RED:   colour_green_o <= 1'b0;
            TCM_COL_GREEN: colour_green_o <= 1'b1;
            TCM_COL_R2G:   colour_green_o <= on_any;  // R16
            TCM_COL_G2R:   colour_green_o <= !on_any; // R17
         endcase
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         disp_value_o    <= 32'h0;
         decimal_place_o <= 2'h0;
         cfg_mode_o      <= 1'b0;
      end
      else
      begin
         decimal_place_o <= act_reg.dp; // R4
         cfg_mode_o      <= (kst_reg == TCM_K_CFG);
         if (kst_reg != TCM_K_CFG)
            disp_value_o <= meas_reg;
         else if (mon_idx_reg != 4'h0)
            disp_value_o <= {24'h0, 4'(mon_idx_reg),
                             3'h0, sw_pins[3'(mon_idx_reg - 4'h1)]}; // R23
         else
            disp_value_o <= 32'(cfg_pend_reg);
      end
   end
endmodule

// ==== dv/tcm_properties.sv ====
`timescale 1ns/1ps
module tcm_properties (
   input wire logic                 clk_i,
   input wire logic                 rst_i,
   input wire tcm_pkg::tcm_wb_req_s wb_req_i,
   input wire logic                 wb_ack_o,
   input wire logic                 mode_key_i,
   input wire logic                 up1_key_i,
   input wire logic [7:0]           switch_pins_i,
   input wire logic                 first_setpoint_output_o,
   input wire logic                 second_setpoint_output_o,
   input wire logic [31:0]          disp_value_o,
   input wire logic                 cfg_mode_o
);
   import tcm_pkg::*;
   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   wire logic req = wb_req_i.cyc && wb_req_i.stb;
   wire logic both = mode_key_i && up1_key_i;
   wire logic outs = first_setpoint_output_o || second_setpoint_output_o;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Sixteen held cycles cover sync latency plus the shortened hold
   sequence s_hold;
      both [*8] ##1 both [*8];
   endsequence
   AST_ACK_NEXT: assert property ($rose(req) |=> wb_ack_o)
      else $error("ack late");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(req))
      else $error("ack without request");
   AST_ENTRY: assert property (
      (mode_key_i && !up1_key_i && !cfg_mode_o) [*2] ##1 s_hold |-> cfg_mode_o)
      else $error("entry missed");
   AST_UP1_FIRST: assert property (
      (!mode_key_i && up1_key_i && !cfg_mode_o) ##1 s_hold |-> !cfg_mode_o)
      else $error("entry after wrong order");
   AST_CFG_QUIET: assert property (cfg_mode_o |-> !outs)
      else $error("output on in config mode");
   AST_RET_QUIET: assert property ($fell(cfg_mode_o) |->
      !$past(outs) && disp_value_o == 32'h0)
      else $error("output on at return");
   AST_MON_RANGE: assert property (
      cfg_mode_o && $past(cfg_mode_o) |-> disp_value_o[7:4] <= 4'h8)
      else $error("monitor index out of range");
   AST_MON_OFF: assert property (
      (cfg_mode_o && !switch_pins_i[0]) [*4] |=> disp_value_o[7:4] == 4'h0)
      else $error("monitor shown with pin one off");
endmodule

bind tcm_top tcm_properties chk_u (.clk_i, .rst_i, .wb_req_i, .wb_ack_o,
   .mode_key_i, .up1_key_i, .switch_pins_i, .first_setpoint_output_o,
   .second_setpoint_output_o, .disp_value_o, .cfg_mode_o);

// ==== dv/tcm_pulse_src.sv ====
`timescale 1ns/1ps
module tcm_pulse_src #(
   parameter int unsigned HALF = 5
)(
   // Clock and enable
   input  wire logic clk_i,
   input  wire logic en_i,
   // Pulse line
   output logic      pulse_o
);
   // -------------------------------------------------------------
   // Pulse source
   // -------------------------------------------------------------
   int unsigned cnt_reg;
   // Idle low while stopped, as an open contact with pull-down
   always_ff @(posedge clk_i)
   begin
      if (!en_i || cnt_reg == HALF - 1)
         cnt_reg <= 0;
      else
         cnt_reg <= cnt_reg + 1;
      if (!en_i)
         pulse_o <= 1'b0;
      else if (cnt_reg == HALF - 1)
         pulse_o <= !pulse_o;
   end
endmodule

// ==== dv/tcm_top_bench.sv ====
`timescale 1ns/1ps
module tcm_top_bench;
   import tcm_pkg::*;
   // -------------------------------------------------------------
   // Bench
   // -------------------------------------------------------------
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   tcm_wb_req_s req   = '0;
   logic [31:0] wb_dat, disp, rdat;
   logic        wb_ack, pulse, first_setpoint_output, second_setpoint_output, green, cfg;
   logic        en = 1'b0, mode = 1'b0, up1 = 1'b0, up2 = 1'b0;
   logic [7:0]  sw = 8'h00;
   logic [1:0]  dp;
   int          n_mismatch = 0;
   int          n_compared = 0;
   always #25 clk_i = !clk_i;
   tcm_pulse_src src_u (.clk_i, .en_i(en), .pulse_o(pulse));
   tcm_top #(.SAMPLE_CYC(100), .TENTH_CYC(20), .HOLD_CYC(10), .DEB_CYC(4))
   dut_u (.clk_i, .rst_i, .wb_req_i(req), .wb_dat_o(wb_dat),
      .wb_ack_o(wb_ack), .first_pulse_input_i(pulse), .mode_key_i(mode),
      .up1_key_i(up1), .up2_key_i(up2), .switch_pins_i(sw),
      .first_setpoint_output_o(first_setpoint_output), .second_setpoint_output_o(second_setpoint_output),
      .colour_green_o(green), .disp_value_o(disp), .decimal_place_o(dp),
      .cfg_mode_o(cfg));
   task automatic give_verdict;
      if (n_mismatch == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      req <= '{adr: a, dat: d, sel: 4'hF, we: w, cyc: 1'b1, stb: 1'b1};
      do @(posedge clk_i); while (wb_ack !== 1'b1);
      rdat = wb_dat;
      req <= '0;
      @(posedge clk_i);
   endtask
   task automatic keys(input logic m, input logic u, input int n);
      mode <= m;
      up1 <= u;
      repeat (n) @(posedge clk_i);
   endtask
   task automatic t_regs;
      wb(8'h04, 1'b0, '0);
      chk(rdat, 32'h0000_03E8);
      wb(8'h08, 1'b0, '0);
      chk(rdat, 32'h0000_03E7);
      wb(8'h0C, 1'b1, 32'h0000_0005);
      wb(8'h0C, 1'b0, '0);
      chk(rdat, 32'h0000_0000);
      wb(8'h40, 1'b0, '0);
      chk(rdat, 32'h0000_0000);
      wb(8'h10, 1'b1, 32'h0000_0050);
   endtask
   task automatic t_keys;
      keys(1'b0, 1'b1, 3);
      keys(1'b1, 1'b1, 20);
      chk(cfg, 1'b0);
      keys(1'b0, 1'b0, 6);
      keys(1'b1, 1'b0, 3);
      keys(1'b1, 1'b1, 20);
      chk({first_setpoint_output, second_setpoint_output, cfg}, 3'b001);
      keys(1'b0, 1'b0, 6);
      repeat (4)
      begin
         keys(1'b0, 1'b1, 4);
         keys(1'b0, 1'b0, 4);
      end
      chk(disp, 32'h0000_0005);
      sw <= 8'h01;
      up2 <= 1'b1;
      repeat (4) @(posedge clk_i);
      up2 <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk(disp[7:0], 8'h11);
      sw <= 8'h00;
      repeat (8) @(posedge clk_i);
      chk(disp[7:4], 4'h0);
      keys(1'b1, 1'b0, 4);
      keys(1'b0, 1'b0, 8);
      chk({first_setpoint_output, second_setpoint_output, cfg}, 3'b110);
      chk(disp, 32'h0);
   endtask
   task automatic t_meas;
      wb(8'h18, 1'b1, 32'h0000_0001);
      wb(8'h00, 1'b1, 32'h0000_0214);
      wb(8'h04, 1'b1, 32'h0000_07D0);
      wb(8'h08, 1'b1, 32'h0000_0005);
      wb(8'h18, 1'b1, 32'h0000_0000);
      wb(8'h10, 1'b1, 32'h0000_0050);
      en <= 1'b1;
      repeat (500) @(posedge clk_i);
      chk(disp, 32'h0000_0064);
      chk({first_setpoint_output, second_setpoint_output, green}, 3'b101);
      chk(dp, 2'h2);
      en <= 1'b0;
      repeat (300) @(posedge clk_i);
      chk(disp, 32'h0);
      chk({first_setpoint_output, second_setpoint_output, green}, 3'b011);
   endtask
   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_keys();
      t_meas();
      give_verdict();
   end
   // Whole run is under two thousand cycles; allow ample margin
   initial
   begin
      repeat (6000) @(posedge clk_i);
      n_mismatch++;
      give_verdict();
   end
endmodule
